// ### hw/csbi_socket_if.sv
// card socket bus interface: answer fifo, per-slot engine and two-slot top
// assumes pins from the card reach the ports unsynchronised and pin
// direction is resolved outside from the *_oe outputs
`include "csbi_defs.svh"
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// answer fifo: valid/ready on both sides, depth a power of two
module csbi_fifo #(
	parameter int WIDTH = 35,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             resetn_i,
	// filling side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// draining side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);
	localparam int AW = $clog2(DEPTH);

	// storage and pointers with a wrap bit
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0]                 wr;
		logic [AW:0]                 rd;
	} csbi_fifo_st_t;

	csbi_fifo_st_t q;   // registered state
	csbi_fifo_st_t d;   // next state
	logic          full;
	logic          empty;

	// full when pointers differ only in the wrap bit
	assign full        = (q.wr[AW] != q.rd[AW]) && (q.wr[AW-1:0] == q.rd[AW-1:0]);
	assign empty       = q.wr == q.rd;
	assign in_ready_o  = !full;
	assign out_valid_o = !empty;
	assign out_data_o  = q.mem[q.rd[AW-1:0]];

	// push and pop
	always_comb begin
		d = q;
		if (in_valid_i && !full) begin
			d.mem[q.wr[AW-1:0]] = in_data_i;
			d.wr                = q.wr + 1'b1;
		end
		if (out_ready_i && !empty) begin
			d.rd = q.rd + 1'b1;
		end
	end

	// pointers reset, storage keeps its contents
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			q.wr <= '0;
			q.rd <= '0;
		end else begin
			q <= d;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
// one socket: 16-bit card cycles, cardbus initiator and target
module csbi_slot (
	// clock and reset
	input  wire logic                   clk_i,
	input  wire logic                   resetn_i,
	// host requests
	input  wire logic                   req_valid_i,
	output logic                        req_ready_o,
	input  wire csbi_pkg::csbi_req_t    req_i,
	// answers
	output logic                        rsp_valid_o,
	input  wire logic                   rsp_ready_i,
	output csbi_pkg::csbi_rsp_t         rsp_o,
	// slot control and status
	input  wire logic                   cardbus_i,
	input  wire logic                   cclk_stop_i,
	input  wire logic                   card_reset_i,
	output csbi_pkg::csbi_stat_t        stat_o,
	output logic                        spkr_o,
	// card pins
	input  wire csbi_pkg::csbi_pin_in_t pin_i,
	output csbi_pkg::csbi_pc16_out_t    pc16_o,
	output csbi_pkg::csbi_cb_out_t      cb_o
);
	import csbi_pkg::*;

	// idle 16-bit pins: every strobe high, data released
	localparam csbi_pc16_out_t PC16_IDLE = '{a: '0, d: '0, d_oe: 1'b0, ce1_n: 1'b1, ce2_n: 1'b1,
		oe_n: 1'b1, we_n: 1'b1, iord_n: 1'b1, iowr_n: 1'b1, reg_n: 1'b1, reset: 1'b0};
	// cardbus pins while the card is held in reset: all driven, all idle
	localparam csbi_cb_out_t CB_IDLE = '{cclk: 1'b0, crst_n: 1'b0, crst_oe: 1'b1, cad: '0,
		cad_oe: 1'b1, cbe: '0, cbe_oe: 1'b1, par: 1'b0, par_oe: 1'b1, frame_n: 1'b1,
		frame_oe: 1'b1, irdy_n: 1'b1, irdy_oe: 1'b1, trdy_n: 1'b1, devsel_n: 1'b1,
		stop_n: 1'b1, tgt_oe: 1'b1, perr_n: 1'b1, perr_oe: 1'b1};

	csbi_slot_st_t q;          // registered state
	csbi_slot_st_t d;          // next state
	logic          fin_ready;  // answer fifo has room
	logic          run;        // card clock may run
	logic          samp;       // pins now hold the values of the last rising card clock
	logic          rst_act;    // card reset requested or still timing
	logic          op_wr;      // held request writes toward the card
	logic          xfer;       // target data phase completes now
	logic          cclk_keep;  // card clock kept across the reset override

	// answer buffer
	csbi_fifo #(
		.WIDTH($bits(csbi_rsp_t)),
		.DEPTH(`CSBI_FIFO_DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.resetn_i    (resetn_i),
		.in_valid_i  (q.push),
		.in_ready_o  (fin_ready),
		.in_data_i   (q.rsp),
		.out_valid_o (rsp_valid_o),
		.out_ready_i (rsp_ready_i),
		.out_data_o  (rsp_o)
	);

	// outputs straight from the state
	assign pc16_o = q.p;
	assign cb_o   = q.c;
	assign spkr_o = q.s2.spkr;
	assign stat_o = '{rdy_irq: q.s2.ready, wp: q.s2.wp && !cardbus_i, perr: !q.c.perr_n};

	// next-state logic
	always_comb begin
		d         = q;
		cclk_keep = 1'b0;
		xfer      = 1'b0;
		op_wr     = csbi_op_writes(q.req.op);
		// two-flop synchroniser on every card pin
		d.s1      = pin_i;
		d.s2      = q.s1;
		d.push    = 1'b0;

		// card clock divider; stops only low and only while idle
		run = cardbus_i && (!cclk_stop_i || q.st != CSBI_ST_IDLE || !q.c.crst_n);
		if (q.div == `CSBI_CCLK_DIV_LAST) begin
			d.div    = 2'h0;
			d.c.cclk = run ? !q.c.cclk : 1'b0;
		end else begin
			d.div = q.div + 2'h1;
		end
		// rising card clock, seen through the synchroniser delay
		d.rise = {q.rise[0], (q.div == `CSBI_CCLK_DIV_LAST) && !q.c.cclk && run};
		samp   = q.rise[1];

		// card reset width and reset pins
		rst_act = card_reset_i || (q.rst_cnt != '0);
		if (card_reset_i) begin
			d.rst_cnt = csbi_cnt_t'(`CSBI_CRESET_CYC);
		end else if (q.rst_cnt != '0) begin
			d.rst_cnt = q.rst_cnt - 1'b1;
		end
		d.p.reset = rst_act && !cardbus_i;
		if (rst_act) begin
			d.c.crst_n = 1'b0;
		end else if (samp) begin
			d.c.crst_n = 1'b1;
		end

		// host handshake: one operation at a time, only with room for its answer
		req_ready_o = (q.st == CSBI_ST_IDLE) && fin_ready && !rst_act &&
			(cardbus_i ? (samp && q.c.crst_n && q.s2.frame_n) : !q.p.reset);

		// parity follows our own drive one card clock later, parity error reporting
		if (samp) begin
			d.c.par    = ^{q.c.cad, q.c.cbe};
			d.c.par_oe = q.c.cad_oe;
			d.chk      = 1'b0;
			if (q.chk && (q.chk_par != q.s2.par)) begin
				d.c.perr_n  = 1'b0;
				d.c.perr_oe = 1'b1;
			end else if (!q.c.perr_n) begin
				d.c.perr_n = 1'b1;
			end else if (q.c.crst_n) begin
				d.c.perr_oe = 1'b0;
			end
		end

		unique case (q.st)
			// wait for a host request or a card-started cycle
			CSBI_ST_IDLE: begin
				if (req_valid_i && req_ready_o) begin
					d.req      = req_i;
					d.rsp      = '0;
					d.tmo      = 3'h0;
					if (cardbus_i) begin
						// address phase: address on cad, command on cbe
						d.c.frame_n  = 1'b0;
						d.c.frame_oe = 1'b1;
						d.c.cad      = req_i.addr;
						d.c.cad_oe   = 1'b1;
						d.c.cbe      = csbi_op_io(req_i.op) ?
							(csbi_op_writes(req_i.op) ? `CSBI_CMD_IO_WR : `CSBI_CMD_IO_RD) :
							(csbi_op_writes(req_i.op) ? `CSBI_CMD_MEM_WR : `CSBI_CMD_MEM_RD);
						d.c.cbe_oe   = 1'b1;
						d.c.irdy_n   = 1'b1;
						d.c.irdy_oe  = 1'b1;
						d.st         = CSBI_ST_C_ADDR;
					end else begin
						// 16-bit setup: address, space select, enables, write data
						d.p.a      = req_i.addr[25:0];
						d.p.reg_n  = !(req_i.attr || csbi_op_io(req_i.op) ||
							req_i.op == CSBI_OP_DMA_FROM_CARD || req_i.op == CSBI_OP_DMA_TO_CARD);
						d.p.ce1_n  = !req_i.be[0];
						d.p.ce2_n  = !req_i.be[1];
						d.p.d      = req_i.wdata[15:0];
						d.p.d_oe   = csbi_op_writes(req_i.op);
						d.cnt      = csbi_cnt_t'(`CSBI_SETUP_CYC);
						d.st       = CSBI_ST_P_SETUP;
					end
				end else if (cardbus_i && samp && q.c.crst_n && !q.s2.frame_n && fin_ready) begin
					// card starts a cycle: claim it
					d.tgt_cmd    = q.s2.cbe;
					d.c.devsel_n = 1'b0;
					d.c.trdy_n   = 1'b1;
					d.c.stop_n   = 1'b1;
					d.c.tgt_oe   = 1'b1;
					d.st         = CSBI_ST_T_DATA;
				end else if (samp && q.c.crst_n) begin
					// bus parked by the card side
					d.c.cad_oe   = 1'b0;
					d.c.cbe_oe   = 1'b0;
					d.c.frame_oe = 1'b0;
					d.c.irdy_oe  = 1'b0;
					d.c.tgt_oe   = 1'b0;
				end
			end
			// 16-bit address setup, then the strobe for the operation
			CSBI_ST_P_SETUP: begin
				if (q.cnt != '0) begin
					d.cnt = q.cnt - 1'b1;
				end else begin
					d.cnt = csbi_cnt_t'(`CSBI_STROBE_CYC);
					d.st  = CSBI_ST_P_STROBE;
					unique case (q.req.op)
						CSBI_OP_MEM_RD: d.p.oe_n = 1'b0;
						CSBI_OP_MEM_WR: d.p.we_n = 1'b0;
						CSBI_OP_IO_RD: d.p.iord_n = 1'b0;
						CSBI_OP_IO_WR: d.p.iowr_n = 1'b0;
						CSBI_OP_DMA_FROM_CARD: begin
							d.p.iord_n = 1'b0;
							d.p.oe_n   = !q.req.last;
						end
						CSBI_OP_DMA_TO_CARD: begin
							d.p.iowr_n = 1'b0;
							d.p.we_n   = !q.req.last;
						end
						default: begin
							// unknown code: end the cycle with an error
							d.rsp.err = 1'b1;
							d.cnt     = '0;
							d.st      = CSBI_ST_P_HOLD;
						end
					endcase
				end
			end
			// strobe low for its width and for as long as wait is held
			CSBI_ST_P_STROBE: begin
				if (q.cnt != '0) begin
					d.cnt = q.cnt - 1'b1;
				end else if (q.s2.wait_n) begin
					d.rsp.data = {16'h0, q.s2.d};
					d.rsp.io16 = csbi_op_io(q.req.op) && !q.s2.wp;
					d.p.oe_n   = 1'b1;
					d.p.we_n   = 1'b1;
					d.p.iord_n = 1'b1;
					d.p.iowr_n = 1'b1;
					d.cnt      = csbi_cnt_t'(`CSBI_HOLD_CYC);
					d.st       = CSBI_ST_P_HOLD;
				end
			end
			// hold address and data, then answer
			CSBI_ST_P_HOLD: begin
				if (q.cnt != '0) begin
					d.cnt = q.cnt - 1'b1;
				end else begin
					d.p.d_oe  = 1'b0;
					d.p.reg_n = 1'b1;
					d.p.ce1_n = 1'b1;
					d.p.ce2_n = 1'b1;
					d.push    = 1'b1;
					d.st      = CSBI_ST_IDLE;
				end
			end
			// single data phase: frame released, byte enables and write data out
			CSBI_ST_C_ADDR: begin
				if (samp) begin
					d.c.frame_n = 1'b1;
					d.c.irdy_n  = 1'b0;
					d.c.cbe     = ~q.req.be;
					d.c.cad     = q.req.wdata;
					d.c.cad_oe  = op_wr;
					d.st        = CSBI_ST_C_DATA;
				end
			end
			// wait for the target, stop or the abort timeout
			CSBI_ST_C_DATA: begin
				if (samp) begin
					if (!q.s2.irdy_n && !q.s2.trdy_n && !q.s2.devsel_n) begin
						d.rsp.data = op_wr ? q.req.wdata : q.s2.cad;
						d.chk      = !op_wr;
						d.chk_par  = ^{q.s2.cad, q.s2.cbe};
						d.push     = 1'b1;
						d.st       = CSBI_ST_C_TURN;
					end else if (!q.s2.stop_n) begin
						d.rsp.err = 1'b1;
						d.push    = 1'b1;
						d.st      = CSBI_ST_C_TURN;
					end else if (q.s2.devsel_n && q.tmo == `CSBI_ABORT_TICKS) begin
						d.rsp.err = 1'b1;
						d.push    = 1'b1;
						d.st      = CSBI_ST_C_TURN;
					end else begin
						d.tmo = q.tmo + 3'h1;
					end
					if (d.st == CSBI_ST_C_TURN) begin
						d.c.irdy_n = 1'b1;
						d.c.cad_oe = 1'b0;
					end
				end
			end
			// turnaround: release what was driven
			CSBI_ST_C_TURN: begin
				if (samp) begin
					d.c.frame_oe = 1'b0;
					d.c.irdy_oe  = 1'b0;
					d.c.cbe_oe   = 1'b0;
					d.c.cad_oe   = 1'b0;
					d.c.tgt_oe   = 1'b0;
					d.st         = CSBI_ST_IDLE;
				end
			end
			// target data phases; write data goes to the answer buffer
			CSBI_ST_T_DATA: begin
				if (samp) begin
					xfer        = !q.s2.irdy_n && !q.c.trdy_n;
					d.c.trdy_n  = !(fin_ready && !xfer);
					d.c.cad     = '0;
					d.c.cad_oe  = !q.tgt_cmd[0];
					if (xfer && q.tgt_cmd[0]) begin
						d.rsp   = '{data: q.s2.cad, err: 1'b0, tgt: 1'b1, io16: 1'b0};
						d.push  = 1'b1;
						d.chk   = q.tgt_cmd != `CSBI_CMD_SPECIAL;
						d.chk_par = ^{q.s2.cad, q.s2.cbe};
					end
					if ((xfer || q.s2.irdy_n) && q.s2.frame_n) begin
						d.c.devsel_n = 1'b1;
						d.c.trdy_n   = 1'b1;
						d.c.cad_oe   = 1'b0;
						d.st         = CSBI_ST_C_TURN;
					end
				end
			end
		endcase

		// card reset ends any host cycle with an error answer
		if (rst_act && q.st != CSBI_ST_IDLE && q.st != CSBI_ST_T_DATA) begin
			d.rsp.err = 1'b1;
			d.push    = 1'b1;
			d.st      = CSBI_ST_IDLE;
			d.p       = PC16_IDLE;
			d.p.reset = !cardbus_i;
		end
		// while in reset every cardbus pin but the card clock is driven to its idle level
		if (!d.c.crst_n) begin
			cclk_keep = d.c.cclk;
			d.c       = CB_IDLE;
			d.c.cclk  = cclk_keep;
			if (d.st == CSBI_ST_T_DATA) begin
				d.st = CSBI_ST_IDLE;
			end
		end
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			q   <= '0;
			q.p <= PC16_IDLE;
			q.c <= CB_IDLE;
		end else begin
			q <= d;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
// two independent sockets and the combined speaker output
module csbi_socket_if (
	// clock and reset
	input  wire logic                         clk_i,
	input  wire logic                         resetn_i,
	// host requests per slot
	input  wire logic [1:0]                   req_valid_i,
	output logic [1:0]                        req_ready_o,
	input  wire csbi_pkg::csbi_req_t [1:0]    req_i,
	// answers per slot
	output logic [1:0]                        rsp_valid_o,
	input  wire logic [1:0]                   rsp_ready_i,
	output csbi_pkg::csbi_rsp_t [1:0]         rsp_o,
	// slot control and status
	input  wire logic [1:0]                   cardbus_i,
	input  wire logic [1:0]                   cclk_stop_i,
	input  wire logic [1:0]                   card_reset_i,
	output csbi_pkg::csbi_stat_t [1:0]        stat_o,
	// card pins per slot
	input  wire csbi_pkg::csbi_pin_in_t [1:0] pin_i,
	output csbi_pkg::csbi_pc16_out_t [1:0]    pc16_o,
	output csbi_pkg::csbi_cb_out_t [1:0]      cb_o,
	// audio to the host
	output logic                              combined_speaker_output_o
);
	import csbi_pkg::*;

	csbi_top_st_t q;      // registered state
	csbi_top_st_t d;      // next state
	logic [1:0]   spkr;   // synchronised audio per slot

	// one engine per slot, nothing shared between them
	for (genvar i = 0; i < 2; i++) begin : g_slot
		csbi_slot u_slot (
			.clk_i        (clk_i),
			.resetn_i     (resetn_i),
			.req_valid_i  (req_valid_i[i]),
			.req_ready_o  (req_ready_o[i]),
			.req_i        (req_i[i]),
			.rsp_valid_o  (rsp_valid_o[i]),
			.rsp_ready_i  (rsp_ready_i[i]),
			.rsp_o        (rsp_o[i]),
			.cardbus_i    (cardbus_i[i]),
			.cclk_stop_i  (cclk_stop_i[i]),
			.card_reset_i (card_reset_i[i]),
			.stat_o       (stat_o[i]),
			.spkr_o       (spkr[i]),
			.pin_i        (pin_i[i]),
			.pc16_o       (pc16_o[i]),
			.cb_o         (cb_o[i])
		);
	end

	assign combined_speaker_output_o = q.spk;

	// speaker is the exclusive-or of both slots
	always_comb begin
		d     = q;
		d.spk = ^spkr;
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule

`default_nettype wire

// ### hw/csbi_defs.svh
// card socket bus interface: timing counts, divider settings and bus commands
// assumes a 125 MHz core clock; every figure below is a `define
`ifndef CSBI_DEFS_SVH
`define CSBI_DEFS_SVH

// core clock period in ns
`define CSBI_CLK_NS          8
// card clock: toggle when the divider reaches this count (divide by four)
`define CSBI_CCLK_DIV_LAST   2'h1
// 16-bit card cycle: address setup, strobe width and hold, in ns and in cycles
`define CSBI_SETUP_NS        30
`define CSBI_SETUP_CYC       ((`CSBI_SETUP_NS + `CSBI_CLK_NS - 1) / `CSBI_CLK_NS)
`define CSBI_STROBE_NS       150
`define CSBI_STROBE_CYC      ((`CSBI_STROBE_NS + `CSBI_CLK_NS - 1) / `CSBI_CLK_NS)
`define CSBI_HOLD_NS         20
`define CSBI_HOLD_CYC        ((`CSBI_HOLD_NS + `CSBI_CLK_NS - 1) / `CSBI_CLK_NS)
// least width of the card reset, in us and in cycles
`define CSBI_CRESET_US       10
`define CSBI_CRESET_CYC      ((`CSBI_CRESET_US * 1000 + `CSBI_CLK_NS - 1) / `CSBI_CLK_NS)
// card clock edges to wait for a device select before an initiator abort
`define CSBI_ABORT_TICKS     3'h5
// cardbus bus commands
`define CSBI_CMD_SPECIAL     4'h1
`define CSBI_CMD_IO_RD       4'h2
`define CSBI_CMD_IO_WR       4'h3
`define CSBI_CMD_MEM_RD      4'h6
`define CSBI_CMD_MEM_WR      4'h7
// depth of the answer buffer per slot
`define CSBI_FIFO_DEPTH      16

`endif

// ### hw/csbi_pkg.sv
// card socket bus interface: shared types
// assumes nothing beyond a SystemVerilog compiler
package csbi_pkg;

	// counter for timed phases
	typedef logic [10:0] csbi_cnt_t;

	// host operations on a slot
	typedef enum logic [2:0] {
		CSBI_OP_MEM_RD,
		CSBI_OP_MEM_WR,
		CSBI_OP_IO_RD,
		CSBI_OP_IO_WR,
		CSBI_OP_DMA_FROM_CARD,
		CSBI_OP_DMA_TO_CARD
	} csbi_op_t;

	// slot engine states
	typedef enum logic [3:0] {
		CSBI_ST_IDLE,
		CSBI_ST_P_SETUP,
		CSBI_ST_P_STROBE,
		CSBI_ST_P_HOLD,
		CSBI_ST_C_ADDR,
		CSBI_ST_C_DATA,
		CSBI_ST_C_TURN,
		CSBI_ST_T_DATA
	} csbi_state_t;

	// host request
	typedef struct packed {
		csbi_op_t    op;     // operation
		logic        attr;   // attribute memory space
		logic        last;   // last dma transfer (terminal count)
		logic [31:0] addr;   // card address
		logic [31:0] wdata;  // write data
		logic [3:0]  be;     // byte enables, active high
	} csbi_req_t;

	// answer to the host
	typedef struct packed {
		logic [31:0] data;   // read data or target write data
		logic        err;    // abort, stop, reset or unknown operation code
		logic        tgt;    // word written by the card as initiator
		logic        io16;   // port answered as 16-bit
	} csbi_rsp_t;

	// slot status
	typedef struct packed {
		logic rdy_irq;       // ready or interrupt request line level
		logic wp;            // write protect switch (16-bit mode)
		logic perr;          // parity error being reported
	} csbi_stat_t;

	// card pins read by the block
	typedef struct packed {
		logic        wait_n;
		logic        ready;
		logic        wp;
		logic        spkr;
		logic [15:0] d;
		logic [31:0] cad;
		logic [3:0]  cbe;
		logic        par;
		logic        frame_n;
		logic        irdy_n;
		logic        trdy_n;
		logic        devsel_n;
		logic        stop_n;
	} csbi_pin_in_t;

	// 16-bit card pins driven by the block
	typedef struct packed {
		logic [25:0] a;
		logic [15:0] d;
		logic        d_oe;
		logic        ce1_n;
		logic        ce2_n;
		logic        oe_n;
		logic        we_n;
		logic        iord_n;
		logic        iowr_n;
		logic        reg_n;
		logic        reset;
	} csbi_pc16_out_t;

	// cardbus pins driven by the block
	typedef struct packed {
		logic        cclk;
		logic        crst_n;
		logic        crst_oe;
		logic [31:0] cad;
		logic        cad_oe;
		logic [3:0]  cbe;
		logic        cbe_oe;
		logic        par;
		logic        par_oe;
		logic        frame_n;
		logic        frame_oe;
		logic        irdy_n;
		logic        irdy_oe;
		logic        trdy_n;
		logic        devsel_n;
		logic        stop_n;
		logic        tgt_oe;
		logic        perr_n;
		logic        perr_oe;
	} csbi_cb_out_t;

	// whole state of one slot engine
	typedef struct packed {
		csbi_pin_in_t   s1;
		csbi_pin_in_t   s2;
		csbi_state_t    st;
		csbi_cnt_t      cnt;
		csbi_cnt_t      rst_cnt;
		logic [1:0]     div;
		logic [1:0]     rise;
		logic [2:0]     tmo;
		csbi_req_t      req;
		logic [3:0]     tgt_cmd;
		logic           chk;
		logic           chk_par;
		logic           push;
		csbi_rsp_t      rsp;
		csbi_pc16_out_t p;
		csbi_cb_out_t   c;
	} csbi_slot_st_t;

	// state of the top level
	typedef struct packed {
		logic spk;
	} csbi_top_st_t;

	// operations that move data toward the card
	function automatic logic csbi_op_writes(input csbi_op_t op);
		return op == CSBI_OP_MEM_WR || op == CSBI_OP_IO_WR || op == CSBI_OP_DMA_TO_CARD;
	endfunction

	// operations in i/o space
	function automatic logic csbi_op_io(input csbi_op_t op);
		return op == CSBI_OP_IO_RD || op == CSBI_OP_IO_WR;
	endfunction

endpackage

// ### tb/csbi_chk.sv
// assertions on the pins of both sockets
// assumes slot 0 holds a 16-bit card and slot 1 a cardbus card
`timescale 1ns/1ps
`default_nettype none
module csbi_chk (
	// clock and reset
	input wire logic	clk_i,
	input wire logic	resetn_i,
	// slot control
	input wire logic [1:0]	cclk_stop_i,
	input wire logic [1:0]	card_reset_i,
	// pins
	input wire csbi_pkg::csbi_pin_in_t [1:0]	pin_i,
	input wire csbi_pkg::csbi_pc16_out_t [1:0]	pc16_o,
	input wire csbi_pkg::csbi_cb_out_t [1:0]	cb_o
);
	import csbi_pkg::*;
	wire csbi_pc16_out_t	p = pc16_o[0]; // 16-bit slot
	wire csbi_cb_out_t	c = cb_o[1]; // cardbus slot
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	oe_pair_a: assert property (!p.oe_n |-> p.we_n && p.iowr_n) else $error("oe pairing");
	io_reg_a: assert property (!(p.iord_n && p.iowr_n) |-> !p.reg_n) else $error("io select");
	wait_hold_a: assert property ((!pin_i[0].wait_n) [*4] ##0 (!p.oe_n && !card_reset_i[0]) |=> !p.oe_n)
		else $error("wait ignored");
	rst_next_a: assert property ($rose(card_reset_i[0]) |=> p.reset) else $error("card reset late");
	cclk_rate_a: assert property ($changed(c.cclk) ##1 !cclk_stop_i[1] |-> $stable(c.cclk) ##1 $changed(c.cclk))
		else $error("card clock rate");
	crst_sync_a: assert property ($rose(c.crst_n) |-> !c.cclk) else $error("reset release");
	crst_oe_a: assert property (!c.crst_n |-> &{c.cad_oe, c.cbe_oe, c.par_oe, c.frame_oe, c.irdy_oe})
		else $error("lines floated");
	frame_last_a: assert property ($rose(c.frame_n) && c.frame_oe |-> !c.irdy_n) else $error("frame early");
endmodule
bind csbi_socket_if csbi_chk i_chk (.clk_i, .resetn_i, .cclk_stop_i, .card_reset_i, .pin_i, .pc16_o, .cb_o);
`default_nettype wire

// ### tb/csbi_card_model.sv
// card model: 16-bit card on slot 0, cardbus target on slot 1
// assumes bridge pins of both slots; resolves the shared lines
`timescale 1ns/1ps
`default_nettype none
module csbi_card_model #(
	parameter logic [15:0]	RD16 = 16'h0,
	parameter logic [31:0]	RD32 = 32'h0
) (
	// scenario controls
	input wire logic	stall_i,
	input wire logic	mute_i,
	// bridge pins
	input wire csbi_pkg::csbi_pc16_out_t	p_i,
	input wire csbi_pkg::csbi_cb_out_t	c_i,
	// wire levels seen by the bridge
	output csbi_pkg::csbi_pin_in_t [1:0]	pin_o
);
	import csbi_pkg::*;
	logic	claim = 1'b0; // cycle claimed
	logic	par = 1'b0; // parity of last transfer
	// claim and parity move on the rising card clock only
	always @(posedge c_i.cclk) begin
		claim <= c_i.crst_n & !mute_i & !(pin_o[1].frame_n & pin_o[1].irdy_n);
		par <= ^{pin_o[1].cad, pin_o[1].cbe};
	end
	// released lines show the card word during a read strobe or claim, its inverse otherwise
	always_comb begin
		pin_o = '1;
		pin_o[0].wait_n = !stall_i;
		// stall also silences slot 0 audio so the speaker mix moves
		pin_o[0].spkr = !stall_i;
		pin_o[0].d = p_i.d_oe ? p_i.d : (p_i.oe_n & p_i.iord_n) ? ~RD16 : RD16;
		pin_o[1].cad = c_i.cad_oe ? c_i.cad : claim ? RD32 : ~RD32;
		pin_o[1].cbe = c_i.cbe_oe ? c_i.cbe : 4'hf;
		// stall corrupts the parity the card returns
		pin_o[1].par = c_i.par_oe ? c_i.par : par ^ stall_i;
		pin_o[1].frame_n = c_i.frame_oe ? c_i.frame_n : 1'b1;
		pin_o[1].irdy_n = c_i.irdy_oe ? c_i.irdy_n : 1'b1;
		pin_o[1].trdy_n = c_i.tgt_oe ? c_i.trdy_n : !claim;
		pin_o[1].devsel_n = c_i.tgt_oe ? c_i.devsel_n : !claim;
	end
endmodule
`default_nettype wire

// ### tb/testbench.sv
// bench: strobe table on slot 0, then wait, fifo, reset and cardbus cases
// assumes the card model sits on the pins
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import csbi_pkg::*;
	localparam logic [15:0]	RD16 = 16'h5a3c;
	localparam logic [31:0]	RD32 = 32'hc3a5_0f1e;
	logic	clk_i = 1'b0, resetn_i = 1'b0, stall = 1'b0, mute = 1'b0;
	logic [1:0]	req_valid_i = '0, rsp_ready_i = '0, cardbus_i = 2'h2, cclk_stop_i = '0, card_reset_i = '0;
	csbi_req_t [1:0]	req_i = '0;
	logic [1:0]	req_ready_o, rsp_valid_o;
	csbi_rsp_t [1:0]	rsp_o;
	csbi_stat_t [1:0]	stat_o;
	csbi_pin_in_t [1:0]	pin_i;
	csbi_pc16_out_t [1:0]	pc16_o;
	csbi_cb_out_t [1:0]	cb_o;
	logic	combined_speaker_output_o;
	int	error_cnt = 0, comparisons = 0, cycles = 0, i;
	csbi_rsp_t	r;
	logic [4:0]	seen; // strobes seen low: oe we iord iowr reg
	// op, attr, last, expected strobes
	logic [9:0]	rows [9] = '{{CSBI_OP_MEM_RD, 2'h0, 5'h10}, {CSBI_OP_MEM_RD, 2'h2, 5'h11},
		{CSBI_OP_MEM_WR, 2'h0, 5'h08}, {CSBI_OP_MEM_WR, 2'h2, 5'h09}, {CSBI_OP_IO_RD, 2'h0, 5'h05},
		{CSBI_OP_IO_WR, 2'h0, 5'h03}, {CSBI_OP_DMA_FROM_CARD, 2'h1, 5'h15},
		{CSBI_OP_DMA_FROM_CARD, 2'h0, 5'h05}, {CSBI_OP_DMA_TO_CARD, 2'h1, 5'h0b}};
	csbi_socket_if i_dut (.clk_i, .resetn_i, .req_valid_i, .req_ready_o, .req_i, .rsp_valid_o, .rsp_ready_i,
		.rsp_o, .cardbus_i, .cclk_stop_i, .card_reset_i, .stat_o, .pin_i, .pc16_o, .cb_o,
		.combined_speaker_output_o);
	csbi_card_model #(.RD16(RD16), .RD32(RD32)) i_card (.stall_i(stall), .mute_i(mute), .p_i(pc16_o[0]),
		.c_i(cb_o[1]), .pin_o(pin_i));
	always #4 clk_i = ~clk_i;
	// hang guard
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			$display("[ERR] cycles expected below 20000 seen 20000");
			finish_test();
		end
	end
	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", n, exp, got);
		end
	endtask
	// request held until taken, entered at a falling edge
	task automatic issue(input int s, input csbi_op_t op, input logic [1:0] al);
		req_i[s] = '{op, al[1], al[0], 32'h40, {16'h0, RD16}, 4'hf};
		req_valid_i[s] = 1'b1;
		repeat (3000) begin
			if (req_ready_o[s] === 1'b1) break;
			@(negedge clk_i);
		end
		if (req_ready_o[s] !== 1'b1) begin
			error_cnt++;
			$display("[ERR] taken expected 1 seen 0");
		end
		@(negedge clk_i);
		req_valid_i[s] = 1'b0;
		@(negedge clk_i);
	endtask
	// wait for an answer, then pop it
	task automatic get(input int s);
		seen = '0;
		repeat (3000) begin
			if (rsp_valid_o[s] === 1'b1) break;
			@(negedge clk_i);
			seen |= ~{pc16_o[0].oe_n, pc16_o[0].we_n, pc16_o[0].iord_n, pc16_o[0].iowr_n, pc16_o[0].reg_n};
		end
		if (rsp_valid_o[s] !== 1'b1) begin
			error_cnt++;
			$display("[ERR] answer expected 1 seen 0");
		end
		r = rsp_o[s];
		rsp_ready_i[s] = 1'b1;
		@(negedge clk_i);
		rsp_ready_i[s] = 1'b0;
		@(negedge clk_i);
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(negedge clk_i);
		resetn_i = 1'b1;
		for (i = 0; i < 9; i++) begin
			issue(0, csbi_op_t'(rows[i][9:7]), rows[i][6:5]);
			get(0);
			chk("strobes", seen, rows[i][4:0]);
			if (!rows[i][3] && !rows[i][1]) chk("data", r.data[15:0], RD16);
		end
		$display("strobe table done");
		stall = 1'b1;
		issue(0, CSBI_OP_MEM_RD, 2'h0);
		repeat (100) @(negedge clk_i);
		chk("stretch", {rsp_valid_o[0], pc16_o[0].oe_n, combined_speaker_output_o}, 3'h1);
		stall = 1'b0;
		get(0);
		chk("late data", r.data[15:0], RD16);
		chk("wp", {stat_o[0].wp, combined_speaker_output_o}, 2'h2);
		for (i = 0; i < 16; i++) issue(0, CSBI_OP_IO_WR, 2'h0);
		repeat (40) @(negedge clk_i);
		chk("full", req_ready_o[0], 1'b0);
		for (i = 0; i < 16; i++) get(0);
		chk("drained", {rsp_valid_o[0], r.io16}, 2'h0);
		$display("wait and fifo done");
		card_reset_i[0] = 1'b1;
		@(negedge clk_i);
		chk("reset", pc16_o[0].reset, 1'b1);
		card_reset_i[0] = 1'b0;
		repeat (1200) @(negedge clk_i);
		chk("reset held", pc16_o[0].reset, 1'b1);
		repeat (100) @(negedge clk_i);
		chk("reset end", pc16_o[0].reset, 1'b0);
		issue(1, CSBI_OP_MEM_RD, 2'h0);
		get(1);
		chk("cb read", r.data, RD32);
		repeat (2) @(negedge clk_i);
		chk("cb flags", {r.err, stat_o[1].perr}, 2'h0);
		stall = 1'b1;
		issue(1, CSBI_OP_MEM_RD, 2'h0);
		get(1);
		repeat (2) @(negedge clk_i);
		chk("perr", stat_o[1].perr, 1'b1);
		stall = 1'b0;
		issue(1, CSBI_OP_IO_WR, 2'h0);
		get(1);
		chk("cb write", r.err, 1'b0);
		mute = 1'b1;
		issue(1, CSBI_OP_MEM_WR, 2'h0);
		get(1);
		chk("abort", r.err, 1'b1);
		cclk_stop_i[1] = 1'b1;
		repeat (8) @(negedge clk_i);
		chk("cclk stop", cb_o[1].cclk, 1'b0);
		repeat (2) @(negedge clk_i);
		chk("cclk held", cb_o[1].cclk, 1'b0);
		$display("reset and cardbus done");
		finish_test();
	end
endmodule
`default_nettype wire
